// File: logic/gtc_pkg.sv
package gtc_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_GATE   = 8'h04;
   localparam logic [7:0] ADDR_COUNT  = 8'h08;
   localparam logic [7:0] ADDR_IRQ    = 8'h0c;
   localparam logic [7:0] ADDR_CMP    = 8'h10;
   localparam logic [7:0] ADDR_CAPT   = 8'h14;
   // control register fields
   localparam int CTRL_ON     = 0;
   localparam int CTRL_BYPASS = 2;
   localparam int CTRL_EXT    = 6;
   localparam int CTRL_SLEEP  = 8;
   localparam int CTRL_WATCHDOG_CONFIG_ENABLE   = 9;
   // gate register fields
   localparam int GATE_SS_LO  = 0;
   localparam int GATE_VAL    = 2;
   localparam int GATE_GO     = 3;
   localparam int GATE_SPM    = 4;
   localparam int GATE_TM     = 5;
   localparam int GATE_POL    = 6;
   localparam int GATE_EN     = 7;
   // interrupt register fields
   localparam int IRQ_OVF_F   = 0;
   localparam int IRQ_GATE_F  = 1;
   localparam int IRQ_OVF_E   = 8;
   localparam int IRQ_GATE_E  = 9;
   localparam int IRQ_PERI_E  = 16;
   localparam int IRQ_GLOB_E  = 17;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam logic [15:0] COUNT_MAX  = 16'hffff;
   typedef enum logic [1:0] {
      GSRC_PIN, GSRC_EIGHT_BIT, GSRC_PERIOD, GSRC_WATCHDOG
   } gtc_gsrc_t;
   typedef struct packed {
      logic       on;
      logic       bypass;
      logic       ext;
      logic       watchdog_config_enable;
   } gtc_ctrl_t;
   typedef struct packed {
      logic       en;
      logic       pol;
      logic       tm;
      logic       spm;
      gtc_gsrc_t  ss;
   } gtc_gate_t;
endpackage : gtc_pkg

// File: logic/gtc_timer.sv
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// [RQ1] sync_bypass set: count clock edges taken without the extra sync stage
// [RQ2] external asynchronous counting keeps running in sleep; overflow wakes
// [RQ3] switching sync/async modes may drop or add one increment
// [RQ4] count reads always return a settled value; byte reads not atomic
// [RQ5] software should stop the counter before writing the count
// [RQ6] with gating, count only while gate equals gate_polarity
// [RQ7] gate_source_select picks pin, eight-bit overflow, period reset, watchdog
// [RQ8] eight-bit timer wrap delivers a rising pulse to the gate
// [RQ9] period-match timer reset delivers a rising pulse to the gate
// [RQ10] gating on with watchdog source powers watchdog regardless of counter_on
// [RQ11] watchdog on only for gating causes no reset or wake
// [RQ12] watchdog interval still chosen by shared prescaler settings
// [RQ13] software must use toggle mode with the watchdog source
// [RQ14] toggle mode flip-flop toggles per rising gate edge; cleared when off
// [RQ15] software must not enable toggle while changing gate polarity
// [RQ16] single-pulse: go arms, count from next edge, go clears at trailing edge
// [RQ17] clearing single-pulse clears go; toggle plus single-pulse counts one cycle
// [RQ18] gate_level_status readable, valid even with gating disabled
// [RQ19] falling edge of gate level sets gate_event_flag, even ungated
// [RQ20] rollover sets overflow_flag; irq needs on, enable, peripheral, global
// [RQ21] counter runs in sleep only in asynchronous mode; overflow wakes
// [RQ22] count is the capture and compare time base
// [RQ23] special event clears count without overflow; software write wins
// [RQ24] counter mode needs a falling clock edge before the first count
// [RQ25] counter_on enables counting, clears toggle flip-flop; gating ignored when off
// [RQ26] gate level and its falling edge registered in the system clock
module gtc_timer
   import gtc_pkg::*;
#(
   parameter int CW = 16
) (
   // clock and reset
   input  wire  logic          clk_sys,
   input  wire  logic          nrst,
   // axi4-lite slave
   input  wire  logic [7:0]    s_axi_awaddr,
   input  wire  logic          s_axi_awvalid,
   output logic                s_axi_awready,
   input  wire  logic [31:0]   s_axi_wdata,
   input  wire  logic [3:0]    s_axi_wstrb,
   input  wire  logic          s_axi_wvalid,
   output logic                s_axi_wready,
   output logic [1:0]          s_axi_bresp,
   output logic                s_axi_bvalid,
   input  wire  logic          s_axi_bready,
   input  wire  logic [7:0]    s_axi_araddr,
   input  wire  logic          s_axi_arvalid,
   output logic                s_axi_arready,
   output logic [31:0]         s_axi_rdata,
   output logic [1:0]          s_axi_rresp,
   output logic                s_axi_rvalid,
   input  wire  logic          s_axi_rready,
   // external pins
   input  wire  logic          counter_clock,
   input  wire  logic          gate_input,
   // internal sources, same clock
   input  wire  logic          instr_tick,
   input  wire  logic          eight_bit_wrap,
   input  wire  logic          period_reset,
   input  wire  logic          watchdog_overflow,
   input  wire  logic          capture_event,
   input  wire  logic          special_event,
   input  wire  logic          in_sleep,
   // outputs
   output logic                watchdog_power,
   output logic                watchdog_reset_ok,
   output logic                irq,
   output logic                wake,
   output logic                compare_match,
   output logic [CW-1:0]       count_out
);
   // ==========================================================
   // registers
   gtc_ctrl_t     ctrl;
   gtc_gate_t     gcfg;
   logic          go;
   logic [CW-1:0] count;
   logic [CW-1:0] cmp_val;
   logic [CW-1:0] capt_val;
   logic          ovf_flag;
   logic          gev_flag;
   logic          ovf_ie;
   logic          gev_ie;
   logic          peri_ie;
   logic          glob_ie;

   // ==========================================================
   // pin synchronisers
   logic [1:0] clk_s;
   logic [1:0] gpin_s;
   logic       clk_s3;
   logic       clk_prev;
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         clk_s  <= 2'b00;
         gpin_s <= 2'b00;
         clk_s3 <= 1'b0;
      end else begin
         clk_s  <= {clk_s[0], counter_clock};
         gpin_s <= {gpin_s[0], gate_input};
         clk_s3 <= clk_s[1];
      end
   end

   // bypass drops the extra stage, so a mode switch can slip one edge
   logic clk_lvl;
   assign clk_lvl = ctrl.bypass ? clk_s[1] : clk_s3; // [RQ1] [RQ3]
   always_ff @(posedge clk_sys) begin
      if (!nrst) clk_prev <= 1'b0;
      else       clk_prev <= clk_lvl;
   end

   // counter mode must see a falling edge before its first count
   logic armed;
   logic wr_count;
   logic clk_rise;
   always_ff @(posedge clk_sys) begin
      if (!nrst)                          armed <= 1'b0;
      else if (!ctrl.on || wr_count)      armed <= 1'b0; // [RQ24]
      else if (clk_prev && !clk_lvl)      armed <= 1'b1; // [RQ24]
   end
   assign clk_rise = ctrl.ext ? (armed && clk_lvl && !clk_prev) : instr_tick;

   // ==========================================================
   // gate path
   logic gsrc;
   logic gsrc_prev;
   logic tog;
   logic gate_lvl;
   logic gate_val;
   logic gate_val_prev;
   always_comb begin
      case (gcfg.ss) // [RQ7]
         GSRC_PIN:       gsrc = gpin_s[1];
         GSRC_EIGHT_BIT: gsrc = eight_bit_wrap;  // [RQ8]
         GSRC_PERIOD:    gsrc = period_reset;    // [RQ9]
         GSRC_WATCHDOG:  gsrc = watchdog_overflow;
         default:        gsrc = 1'b0;
      endcase
   end
   always_ff @(posedge clk_sys) begin
      if (!nrst) gsrc_prev <= 1'b0;
      else       gsrc_prev <= gsrc;
   end
   always_ff @(posedge clk_sys) begin
      if (!nrst)                          tog <= 1'b0;
      else if (!gcfg.tm || !ctrl.on)      tog <= 1'b0;  // [RQ14] [RQ25]
      else if (gsrc && !gsrc_prev)        tog <= !tog;  // [RQ14]
   end
   assign gate_lvl = (gcfg.tm ? tog : gsrc) ~^ gcfg.pol;

   // single pulse: done when the gate falls while go is set
   logic gate_fall;
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         gate_val      <= 1'b0;
         gate_val_prev <= 1'b0;
      end else begin
         gate_val      <= gcfg.spm ? (gate_lvl && go) : gate_lvl; // [RQ26] [RQ18]
         gate_val_prev <= gate_val;
      end
   end
   assign gate_fall = gate_val_prev && !gate_val; // [RQ26]

   logic gate_open;
   logic inc;
   logic ovf_evt;
   assign gate_open = !gcfg.en || gate_val;                         // [RQ6] [RQ16]
   assign inc       = ctrl.on && gate_open && clk_rise;             // [RQ25]
   // sleep freezes a synchronous counter, so no rollover may be flagged then
   logic run_ok;
   assign run_ok    = !in_sleep || (ctrl.ext && ctrl.bypass);       // [RQ2] [RQ21]
   assign ovf_evt   = inc && run_ok && (count == COUNT_MAX) && !wr_count && !special_event;

   // ==========================================================
   // watchdog interaction
   always_comb begin
      watchdog_power    = ctrl.watchdog_config_enable || (gcfg.en && gcfg.ss == GSRC_WATCHDOG); // [RQ10] [RQ12]
      watchdog_reset_ok = ctrl.watchdog_config_enable;                                          // [RQ11]
   end

   // ==========================================================
   // axi4-lite slave
   logic       aw_hold;
   logic       w_hold;
   logic [7:0] aw_q;
   logic [31:0] w_q;
   logic [3:0] ws_q;
   logic       wr_go;
   assign s_axi_awready = !aw_hold && !s_axi_bvalid;
   assign s_axi_wready  = !w_hold && !s_axi_bvalid;
   assign wr_go         = aw_hold && w_hold;
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         aw_hold <= 1'b0;
         w_hold  <= 1'b0;
         aw_q    <= 8'h00;
         w_q     <= 32'h0000_0000;
         ws_q    <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold <= 1'b1;
            aw_q    <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_hold <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold <= 1'b1;
            w_q    <= s_axi_wdata;
            ws_q   <= s_axi_wstrb;
         end else if (wr_go) begin
            w_hold <= 1'b0;
         end
      end
   end

   function automatic logic known(input logic [7:0] a);
      known = (a == ADDR_CTRL) || (a == ADDR_GATE) || (a == ADDR_COUNT) ||
              (a == ADDR_IRQ) || (a == ADDR_CMP) || (a == ADDR_CAPT);
   endfunction : known

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= known(aw_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   logic [CW-1:0] wcount;
   assign wr_count = wr_go && aw_q == ADDR_COUNT && (ws_q[0] || ws_q[1]);
   assign wcount   = {ws_q[1] ? w_q[15:8] : count[15:8], ws_q[0] ? w_q[7:0] : count[7:0]};

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         ctrl    <= '0;
         gcfg    <= '0;
         cmp_val <= '0;
         ovf_ie  <= 1'b0;
         gev_ie  <= 1'b0;
         peri_ie <= 1'b0;
         glob_ie <= 1'b0;
      end else if (wr_go) begin
         if (aw_q == ADDR_CTRL && ws_q[0]) begin
            ctrl.on     <= w_q[CTRL_ON];
            ctrl.bypass <= w_q[CTRL_BYPASS];
            ctrl.ext    <= w_q[CTRL_EXT];
         end
         if (aw_q == ADDR_CTRL && ws_q[1]) ctrl.watchdog_config_enable <= w_q[CTRL_WATCHDOG_CONFIG_ENABLE];
         if (aw_q == ADDR_GATE && ws_q[0]) begin
            gcfg.en  <= w_q[GATE_EN];
            gcfg.pol <= w_q[GATE_POL];
            gcfg.tm  <= w_q[GATE_TM];
            gcfg.spm <= w_q[GATE_SPM];
            gcfg.ss  <= gtc_gsrc_t'(w_q[GATE_SS_LO+:2]);
         end
         if (aw_q == ADDR_CMP) begin
            if (ws_q[0]) cmp_val[7:0]  <= w_q[7:0];
            if (ws_q[1]) cmp_val[15:8] <= w_q[15:8];
         end
         if (aw_q == ADDR_IRQ && ws_q[1]) begin
            ovf_ie <= w_q[IRQ_OVF_E];
            gev_ie <= w_q[IRQ_GATE_E];
         end
         if (aw_q == ADDR_IRQ && ws_q[2]) begin
            peri_ie <= w_q[IRQ_PERI_E];
            glob_ie <= w_q[IRQ_GLOB_E];
         end
      end
   end

   // go: set by software, cleared at the trailing gate edge or with spm off
   logic go_set;
   assign go_set = wr_go && aw_q == ADDR_GATE && ws_q[0] && w_q[GATE_GO] && w_q[GATE_SPM];
   always_ff @(posedge clk_sys) begin
      if (!nrst)                               go <= 1'b0;
      else if (!gcfg.spm && !go_set)           go <= 1'b0; // [RQ17]
      else if (go_set)                         go <= 1'b1; // [RQ16]
      else if (gate_fall)                      go <= 1'b0; // [RQ16] [RQ17]
   end

   // flags: hardware set wins over a software clear (write 1 to clear)
   logic clr_ovf;
   logic clr_gev;
   assign clr_ovf = wr_go && aw_q == ADDR_IRQ && ws_q[0] && w_q[IRQ_OVF_F];
   assign clr_gev = wr_go && aw_q == ADDR_IRQ && ws_q[0] && w_q[IRQ_GATE_F];
   always_ff @(posedge clk_sys) begin
      if (!nrst)           ovf_flag <= 1'b0;
      else if (ovf_evt)    ovf_flag <= 1'b1; // [RQ20]
      else if (clr_ovf)    ovf_flag <= 1'b0;
   end
   always_ff @(posedge clk_sys) begin
      if (!nrst)           gev_flag <= 1'b0;
      else if (gate_fall)  gev_flag <= 1'b1; // [RQ19]
      else if (clr_gev)    gev_flag <= 1'b0;
   end

   // ==========================================================
   // counter
   always_ff @(posedge clk_sys) begin
      if (!nrst)              count <= '0;
      else if (wr_count)      count <= wcount;                         // [RQ23] [RQ5]
      else if (special_event) count <= '0;                             // [RQ23]
      else if (inc && run_ok)
                              count <= count + 1'b1;                   // [RQ2] [RQ21]
   end
   always_ff @(posedge clk_sys) begin
      if (!nrst)              capt_val <= '0;
      else if (capture_event) capt_val <= count;                       // [RQ22]
   end
   assign count_out     = count;                                       // [RQ4]
   assign compare_match = (count == cmp_val);                          // [RQ22]
   assign irq  = glob_ie && peri_ie && ((ovf_flag && ovf_ie && ctrl.on) || (gev_flag && gev_ie));
   assign wake = in_sleep && peri_ie && ((ovf_flag && ovf_ie && ctrl.on) || (gev_flag && gev_ie)); // [RQ21]

   // ==========================================================
   // read channel
   logic [31:0] rd;
   always_comb begin
      rd = 32'h0000_0000;
      case (s_axi_araddr)
         ADDR_CTRL: begin
            rd[CTRL_ON] = ctrl.on;
            rd[CTRL_BYPASS] = ctrl.bypass;
            rd[CTRL_EXT] = ctrl.ext;
            rd[CTRL_WATCHDOG_CONFIG_ENABLE] = ctrl.watchdog_config_enable;
            rd[CTRL_SLEEP] = in_sleep;
         end
         ADDR_GATE: rd[7:0] = {gcfg.en, gcfg.pol, gcfg.tm, gcfg.spm, go, gate_val, gcfg.ss}; // [RQ18]
         ADDR_COUNT: rd[CW-1:0] = count; // [RQ4]
         ADDR_IRQ: begin
            rd[IRQ_OVF_F] = ovf_flag;
            rd[IRQ_GATE_F] = gev_flag;
            rd[IRQ_OVF_E] = ovf_ie;
            rd[IRQ_GATE_E] = gev_ie;
            rd[IRQ_PERI_E] = peri_ie;
            rd[IRQ_GLOB_E] = glob_ie;
         end
         ADDR_CMP:  rd[CW-1:0] = cmp_val;
         ADDR_CAPT: rd[CW-1:0] = capt_val;
         default:   rd = 32'h0000_0000;
      endcase
   end
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd;
         s_axi_rresp  <= known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================================
   // checks
   a_gev_sets: assert property (@(posedge clk_sys) disable iff (!nrst)
      gate_fall |=> gev_flag) else $error("gate fall did not set flag"); // [RQ19]
   a_ovf_sets: assert property (@(posedge clk_sys) disable iff (!nrst)
      ovf_evt |=> ovf_flag && count == '0) else $error("rollover wrong"); // [RQ20]
   a_hold_off: assert property (@(posedge clk_sys) disable iff (!nrst)
      !ctrl.on && !wr_count && !special_event |=> count == $past(count))
      else $error("count moved while off"); // [RQ25]
   a_gate_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
      gcfg.en && !gate_val && !wr_count && !special_event |=> count == $past(count))
      else $error("count moved with gate shut"); // [RQ6]
   a_tog_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
      !gcfg.tm |=> !tog) else $error("toggle not held clear"); // [RQ14]
   a_go_spm: assert property (@(posedge clk_sys) disable iff (!nrst)
      !gcfg.spm && !go_set |=> !go) else $error("go not cleared"); // [RQ17]
   a_sev_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
      special_event && !wr_count |=> count == '0 && !$rose(ovf_flag))
      else $error("special event wrong"); // [RQ23]
   a_wdt_power: assert property (@(posedge clk_sys) disable iff (!nrst)
      gcfg.en && gcfg.ss == GSRC_WATCHDOG |-> watchdog_power)
      else $error("watchdog not powered"); // [RQ10]
   a_arm_first: assert property (@(posedge clk_sys) disable iff (!nrst)
      ctrl.ext && !armed |-> !inc) else $error("count before falling edge"); // [RQ24]
   a_sleep_hold: assert property (@(posedge clk_sys) disable iff (!nrst) // [RQ21]
      in_sleep && !(ctrl.ext && ctrl.bypass) && !wr_count && !special_event
      |=> count == $past(count)) else $error("count moved in sleep");
   c_overflow:  cover property (@(posedge clk_sys) disable iff (!nrst) ovf_evt);
   c_gate_fall: cover property (@(posedge clk_sys) disable iff (!nrst) gate_fall && go);
   c_toggle:    cover property (@(posedge clk_sys) disable iff (!nrst) gcfg.tm && $rose(tog));
endmodule : gtc_timer
`default_nettype wire

// File: verification/gtc_src_model.sv
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// external count clock and gate pin
module gtc_src_model (
   // pins toward the block
   output logic counter_clock,
   output logic gate_input
);
   initial begin
      counter_clock = 1'b0;
      gate_input    = 1'b0;
   end
   // clock rests low between frames; half period 16 ns is the nominal rate
   task automatic frame(input int n, input int half);
      #1.3;
      repeat (n) begin
         #(half) counter_clock = 1'b1;
         #(half) counter_clock = 1'b0;
      end
   endtask : frame
   task automatic gate_to(input logic lvl);
      #3 gate_input = lvl;
   endtask : gate_to
endmodule : gtc_src_model
`default_nettype wire

// File: verification/test_gated_timer_counter16.sv
`timescale 1ns/10ps
`default_nettype none
module test_gated_timer_counter16 import gtc_pkg::*;;
   // =====================================================
   // stimulus and observed signals
   logic        clk_sys       = 1'b0;
   logic        nrst          = 1'b0;
   logic [7:0]  s_axi_awaddr  = 8'h00;
   logic [7:0]  s_axi_araddr  = 8'h00;
   logic [31:0] s_axi_wdata   = 32'h0;
   logic [3:0]  s_axi_wstrb   = 4'hf;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_wvalid  = 1'b0;
   logic        s_axi_bready  = 1'b0;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_rready  = 1'b0;
   logic        instr_tick    = 1'b0;
   logic        capture_event = 1'b0;
   logic        special_event = 1'b0;
   logic        in_sleep      = 1'b0;
   logic [2:0]  gsrc          = 3'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic        counter_clock, gate_input, watchdog_power, watchdog_reset_ok;
   logic        irq, wake, compare_match;
   logic [15:0] count_out;
   typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} gtc_exp_t;
   gtc_exp_t    exp_q[$];
   gtc_exp_t    mon_e;
   int          failures = 0;
   int          checks_done = 0;
   int          cycles = 0;
   logic [31:0] rng = 32'h70b4760f;

   always #2 clk_sys = ~clk_sys;

   gtc_timer dut_u (.clk_sys, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .counter_clock,
      .gate_input, .instr_tick, .eight_bit_wrap(gsrc[0]), .period_reset(gsrc[1]),
      .watchdog_overflow(gsrc[2]), .capture_event, .special_event, .in_sleep,
      .watchdog_power, .watchdog_reset_ok, .irq, .wake, .compare_match, .count_out);
   gtc_src_model src_u (.counter_clock, .gate_input);

   // =====================================================
   // helpers
   task automatic close_out();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, want, seen);
      end
   endtask : check
   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction : xs
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      exp_q.push_back('{d: 32'h0, m: 32'h0, r: RESP_OKAY});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk_sys);
         aw_ok |= s_axi_awready;
         w_ok |= s_axi_wready;
         s_axi_awvalid <= !aw_ok;
         s_axi_wvalid <= !w_ok;
      end
      do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      cyc(1);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m = 32'hffffffff, input logic [1:0] r = RESP_OKAY);
      exp_q.push_back('{d: d, m: m, r: r});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      cyc(1);
   endtask : rd
   task automatic tick(input int n);
      instr_tick <= 1'b1;
      cyc(n);
      instr_tick <= 1'b0;
      cyc(4);
   endtask : tick
   task automatic pulse(input int k);
      gsrc[k] <= 1'b1;
      cyc(1);
      gsrc[k] <= 1'b0;
      cyc(6);
   endtask : pulse
   task automatic gate_pin(input logic l);
      src_u.gate_to(l);
      cyc(6);
   endtask : gate_pin
   // counter is stopped around the count write
   task automatic put_count(input logic [15:0] v, input logic [31:0] c);
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_COUNT, {16'h0, v});
      wr(ADDR_CTRL, c);
   endtask : put_count

   // =====================================================
   // response monitor: oldest note against each answer
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 40000) begin
         failures++;
         close_out();
      end
      if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
         mon_e = exp_q.pop_front();
         if (s_axi_rvalid) begin
            check("rdata", s_axi_rdata & mon_e.m, mon_e.d & mon_e.m);
            check("rresp", {30'h0, s_axi_rresp}, {30'h0, mon_e.r});
         end else
            check("bresp", {30'h0, s_axi_bresp}, {30'h0, mon_e.r});
      end
   end

   // =====================================================
   // scenarios
   initial begin
      logic [15:0] v;
      int          n;
      cyc(16);
      nrst <= 1'b1;
      cyc(2);
      for (int a = 0; a <= 24; a += 4)
         rd(8'(a), 32'h0, 32'hfffffffb, (a == 24) ? RESP_SLVERR : RESP_OKAY);
      check("compare_match", compare_match, 32'h1);
      put_count(16'hfffe, 32'h1);
      tick(2);
      rd(ADDR_COUNT, 32'h0);
      rd(ADDR_IRQ, 32'h1, 32'h1);
      wr(ADDR_IRQ, 32'h10100);
      check("irq", irq, 32'h0);
      wr(ADDR_IRQ, 32'h30100);
      check("irq", irq, 32'h1);
      wr(ADDR_CTRL, 32'h0);
      check("irq", irq, 32'h0);
      wr(ADDR_IRQ, 32'h1);
      rd(ADDR_IRQ, 32'h0, 32'h1);
      put_count(16'hfff0, 32'h1);
      special_event <= 1'b1;
      cyc(1);
      special_event <= 1'b0;
      cyc(2);
      rd(ADDR_COUNT, 32'h0);
      rd(ADDR_IRQ, 32'h0, 32'h1);
      v = 16'(xs());
      put_count(v, 32'h0);
      wr(ADDR_CMP, {16'h0, v});
      check("compare_match", compare_match, 32'h1);
      capture_event <= 1'b1;
      cyc(1);
      capture_event <= 1'b0;
      cyc(2);
      rd(ADDR_CAPT, {16'h0, v});
      check("count_out", {16'h0, count_out}, {16'h0, v});
      wr(ADDR_COUNT, {16'h0, v + 16'h1});
      check("compare_match", compare_match, 32'h0);
      // pin held high: only pin source with high polarity or idle pulses with low polarity count
      gate_pin(1'b1);
      for (int s = 0; s < 8; s++) begin
         n = 1 + int'(xs() % 8);
         wr(ADDR_GATE, 32'h80 | (s[0] ? 32'h40 : 32'h0) | 32'(s >> 1));
         put_count(16'h0, 32'h1);
         tick(n);
         rd(ADDR_COUNT, ((((s >> 1) == 0) == s[0]) ? 32'(n) : 32'h0));
      end
      wr(ADDR_GATE, 32'h40);
      gate_pin(1'b0);
      wr(ADDR_IRQ, 32'h3);
      gate_pin(1'b1);
      rd(ADDR_GATE, 32'h44, 32'hff);
      gate_pin(1'b0);
      rd(ADDR_IRQ, 32'h2, 32'h2);
      wr(ADDR_IRQ, 32'h30200);
      check("irq", irq, 32'h1);
      wr(ADDR_IRQ, 32'h2);
      rd(ADDR_IRQ, 32'h0, 32'h2);
      check("irq", irq, 32'h0);
      for (int k = 1; k < 4; k++) begin
         wr(ADDR_GATE, 32'hc0 | 32'(k));
         wr(ADDR_GATE, 32'he0 | 32'(k));
         put_count(16'h0, 32'h1);
         pulse(k - 1);
         tick(3);
         pulse(k - 1);
         tick(2);
         wr(ADDR_GATE, 32'hc0 | 32'(k));
         tick(2);
         rd(ADDR_COUNT, 32'h3);
      end
      wr(ADDR_GATE, 32'hd0);
      put_count(16'h0, 32'h1);
      wr(ADDR_GATE, 32'hd8);
      gate_pin(1'b1);
      tick(5);
      gate_pin(1'b0);
      rd(ADDR_GATE, 32'h0, 32'h8);
      tick(2);
      gate_pin(1'b1);
      tick(2);
      gate_pin(1'b0);
      rd(ADDR_COUNT, 32'h5);
      wr(ADDR_GATE, 32'hd8);
      wr(ADDR_GATE, 32'hc0);
      rd(ADDR_GATE, 32'h0, 32'h18);
      for (int w = 0; w < 4; w++) begin
         wr(ADDR_CTRL, w[1] ? 32'h200 : 32'h0);
         wr(ADDR_GATE, w[0] ? 32'h83 : 32'h03);
         check("watchdog_power", {31'h0, watchdog_power}, 32'(w != 0));
         check("watchdog_reset_ok", {31'h0, watchdog_reset_ok}, 32'(w[1]));
      end
      wr(ADDR_GATE, 32'h0);
      for (int b = 0; b < 2; b++) begin
         put_count(16'h0, b ? 32'h45 : 32'h41);
         src_u.frame(4, 16);
         cyc(10);
         rd(ADDR_COUNT, 32'h3);
      end
      wr(ADDR_IRQ, 32'h30103);
      in_sleep <= 1'b1;
      put_count(16'hfffe, 32'h45);
      src_u.frame(3, 16);
      cyc(10);
      check("wake", {31'h0, wake}, 32'h1);
      rd(ADDR_COUNT, 32'h0);
      wr(ADDR_IRQ, 32'h30103);
      // synchronous mode in sleep: frozen at the top, no rollover flagged
      put_count(16'hffff, 32'h41);
      src_u.frame(3, 16);
      cyc(10);
      rd(ADDR_COUNT, 32'hffff);
      rd(ADDR_IRQ, 32'h0, 32'h1);
      check("wake", {31'h0, wake}, 32'h0);
      close_out();
   end
endmodule : test_gated_timer_counter16
`default_nettype wire
